// ==== src/edm_mac.sv ====
`timescale 1ns/10ps
// What this block does
// - Half duplex: sense carrier before and watch collisions during each frame.
// - Full duplex: send without deferring and without collision handling.
// - Half duplex: ready frame starts at once when the medium is idle.
// - Busy medium: wait for carrier to drop, then an inter-packet gap.
// - Watch for other energy while sending; a clean frame is done, no retry.
// - On collision stop the data and send a 48-bit jam.
// - After jam, back off a random slot count set by collision count, retry.
// - Descriptor word 0 points to the next descriptor of the list.
// - Descriptor word 1 is the data buffer address.
// - Word 2 bits 31..16 give the offset to the first valid byte.
// - Word 2 bits 15..0 give the valid byte count of the buffer.
// - First-fragment flag in word 3 marks where a new frame begins.
// - Last-fragment flag marks the buffer after which the frame ends.
// - Both flags set: whole packet in one buffer, a one-fragment frame.
// - Word 3 bits 15..0 give total packet length, used on first fragment.
// - Zero next pointer ends the list; the walk stops there.
// - Ownership flag on first fragment; cleared once the packet is done.
module edm_mac (
	input  wire logic        core_clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	output logic             mem_req_o,
	output logic             mem_we_o,
	output logic      [31:0] mem_addr_o,
	output logic      [31:0] mem_wdata_o,
	input  wire logic [31:0] mem_rdata_i,
	input  wire logic        mem_ack_i,
	input  wire logic        mii_tx_clk_i,
	input  wire logic        mii_crs_i,
	input  wire logic        mii_col_i,
	output logic      [3:0]  mii_txd_o,
	output logic             mii_tx_en_o
);
	typedef enum logic [3:0] {
		S_IDLE, S_FETCH, S_CHECK, S_SENSE, S_DEFER, S_IFG, S_PRE,
		S_DATA, S_JAM, S_BACKOFF, S_WB_LAST, S_WB_HEAD
	} edm_state_t;

	typedef struct packed {
		edm_state_t  st;
		logic        en;
		logic        fd_cfg;
		logic        fd;
		logic [31:0] head;
		logic [31:0] cur;
		logic [31:0] pkt_head_addr;
		logic [31:0] nxt;
		logic [31:0] buf_ptr;
		logic [31:0] offlen;
		logic [31:0] flags;
		logic [31:0] head_flags;
		logic [15:0] buf_left;
		logic [15:0] pkt_left;
		logic [1:0]  widx;
		logic        frag;
		logic        drop;
		logic        mreq;
		logic        mwe;
		logic [31:0] maddr;
		logic [31:0] mwdata;
		logic [7:0]  data_byte;
		logic        bvalid;
		logic        hi;
		logic [7:0]  cnt;
		logic [4:0]  attempts;
		logic        txen;
		logic [3:0]  txd;
		logic        bo_start;
		logic        clk_prev;
		logic        underrun;
		logic        abandon;
		logic        format_err;
		logic [15:0] frames;
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} edm_mac_regs_t;

	edm_mac_regs_t q, d;
	logic [2:0]    sync_s;
	logic          tick;
	logic          crs_s;
	logic          col_s;
	logic          on_air;
	logic          txing;
	logic          done_cond;
	logic          apb_wr;

	edm_bo_if bo ();

	// Link clock, carrier and collision all come from the PHY's domain
	edm_sync #(.W(3)) u_sync (
		.core_clk_i (core_clk_i),
		.rst_n_i    (rst_n_i),
		.async_i    ({mii_col_i, mii_crs_i, mii_tx_clk_i}),
		.sync_o     (sync_s)
	);

	edm_backoff u_backoff (
		.core_clk_i (core_clk_i),
		.rst_n_i    (rst_n_i),
		.bo         (bo.unit)
	);

	function automatic logic [31:0] desc_addr(input logic [31:0] base, input logic [1:0] idx);
		desc_addr = {base[31:2], 2'h0} + {28'h0000000, idx, 2'h0};
	endfunction

	// Byte lanes are little endian within a word
	function automatic logic [7:0] pick_byte(input logic [31:0] w, input logic [1:0] lane);
		pick_byte = w[{lane, 3'h0} +: 8];
	endfunction

	// Nibble slot begins at each rising edge of the sampled link clock
	assign crs_s = sync_s[1];
	assign col_s = sync_s[2];
	assign tick = sync_s[0] && !q.clk_prev;
	assign on_air = ((q.st == S_PRE) || (q.st == S_DATA) ||
		(((q.st == S_FETCH) || (q.st == S_CHECK)) && q.frag)) && !q.drop;
	assign txing = (q.st == S_DATA) ||
		(((q.st == S_FETCH) || (q.st == S_CHECK)) && q.frag && !q.drop);
	assign done_cond = (q.pkt_left == 16'h0000) ||
		((q.buf_left == 16'h0000) && q.flags[edm_pkg::LAST_FRAGMENT_FLAG_BIT]);
	assign apb_wr = psel_i && penable_i && q.pready && pwrite_i && !q.pslverr;
	assign bo.start = q.bo_start;
	assign bo.tick = tick;
	assign bo.attempt = q.attempts;

	always_comb begin
		d = q;
		d.clk_prev = sync_s[0];
		d.bo_start = 1'b0;
		// APB: decode in setup, answer with data in the access phase
		d.pready = psel_i && !penable_i;
		d.pslverr = 1'b0;
		d.prdata = 32'h00000000;
		if (psel_i && !penable_i) begin
			if (paddr_i == edm_pkg::REG_CTRL) begin
				d.prdata[edm_pkg::CTRL_EN_BIT] = q.en;
				d.prdata[edm_pkg::CTRL_FD_BIT] = q.fd_cfg;
			end else if (paddr_i == edm_pkg::REG_STAT) begin
				d.prdata[edm_pkg::STAT_BUSY_BIT] = (q.st != S_IDLE);
				d.prdata[edm_pkg::STAT_UNDER_BIT] = q.underrun;
				d.prdata[edm_pkg::STAT_ABANDON_BIT] = q.abandon;
				d.prdata[edm_pkg::STAT_FORMAT_BIT] = q.format_err;
				d.prdata[edm_pkg::STAT_TRY_LSB +: 5] = q.attempts;
			end else if (paddr_i == edm_pkg::REG_HEAD) begin
				d.prdata = q.head;
			end else if (paddr_i == edm_pkg::REG_FRAMES) begin
				d.prdata = {16'h0000, q.frames};
			end else begin
				d.pslverr = 1'b1;
			end
		end
		// Writes; sticky flags clear by writing one, a hardware set below wins
		if (apb_wr) begin
			if (paddr_i == edm_pkg::REG_CTRL) begin
				d.en = pwdata_i[edm_pkg::CTRL_EN_BIT];
				d.fd_cfg = pwdata_i[edm_pkg::CTRL_FD_BIT];
			end else if (paddr_i == edm_pkg::REG_STAT) begin
				d.underrun = q.underrun && !pwdata_i[edm_pkg::STAT_UNDER_BIT];
				d.abandon = q.abandon && !pwdata_i[edm_pkg::STAT_ABANDON_BIT];
				d.format_err = q.format_err && !pwdata_i[edm_pkg::STAT_FORMAT_BIT];
			end else if (paddr_i == edm_pkg::REG_HEAD && q.st == S_IDLE) begin
				d.head = pwdata_i;  // Ignored while a list is being walked
			end
		end
		// Any memory request ends on its acknowledge
		if (q.mreq && mem_ack_i) begin
			d.mreq = 1'b0;
			d.mwe = 1'b0;
		end

		case (q.st)
			S_IDLE: begin
				d.fd = q.fd_cfg;  // Duplex is frozen for a whole packet
				if (q.en && q.head != 32'h00000000) begin
					d.cur = q.head;
					d.pkt_head_addr = q.head;
					d.widx = edm_pkg::DW_NEXT;
					d.frag = 1'b0;
					d.drop = 1'b0;
					d.st = S_FETCH;
				end
			end
			S_FETCH: begin
				if (!q.mreq) begin
					d.mreq = 1'b1;
					d.mwe = 1'b0;
					d.maddr = desc_addr(q.cur, q.widx);
				end else if (mem_ack_i) begin
					case (q.widx)
						edm_pkg::DW_NEXT: d.nxt = mem_rdata_i;
						edm_pkg::DW_BUF: d.buf_ptr = mem_rdata_i;
						edm_pkg::DW_OFFLEN: d.offlen = mem_rdata_i;
						default: d.flags = mem_rdata_i;
					endcase
					d.widx = q.widx + 2'h1;
					if (q.widx == edm_pkg::DW_FLAGS) begin
						d.st = S_CHECK;
					end
				end
			end
			S_CHECK: begin
				// Offset applies since transmit buffers always carry data
				d.buf_ptr = q.buf_ptr + {16'h0000, q.offlen[edm_pkg::OFFSET_LSB +: 16]};
				d.buf_left = q.offlen[edm_pkg::LEN_W-1:0];
				if (q.drop) begin
					// Skipping a packet: walk to its last fragment without sending
					if (q.flags[edm_pkg::LAST_FRAGMENT_FLAG_BIT] || q.nxt == 32'h00000000) begin
						d.st = S_WB_LAST;
					end else begin
						d.cur = q.nxt;
						d.widx = edm_pkg::DW_NEXT;
						d.st = S_FETCH;
					end
				end else if (q.frag) begin
					d.st = S_DATA;
				end else if (!q.flags[edm_pkg::MAC_HOLDS_PACKET_FLAG_BIT]) begin
					d.st = S_IDLE;
				end else if (!q.flags[edm_pkg::FIRST_FRAGMENT_FLAG_BIT]) begin
					d.format_err = 1'b1;
					d.en = 1'b0;
					d.st = S_IDLE;
				end else begin
					d.head_flags = q.flags;
					d.pkt_left = q.flags[edm_pkg::LEN_W-1:0];
					d.bvalid = 1'b0;
					d.hi = 1'b0;
					d.cnt = 8'h00;
					d.st = q.fd ? S_PRE : S_SENSE;
				end
			end
			S_SENSE: begin
				d.cnt = 8'h00;
				d.st = crs_s ? S_DEFER : S_PRE;
			end
			S_DEFER: begin
				if (!crs_s) begin
					d.cnt = 8'h00;
					d.st = S_IFG;
				end
			end
			S_IFG: begin
				if (crs_s) begin
					d.st = S_DEFER;
				end else if (tick) begin
					d.cnt = q.cnt + 8'h01;
					if (q.cnt == edm_pkg::IPG_NIB - 8'h01) begin
						d.cnt = 8'h00;
						d.st = S_PRE;
					end
				end
			end
			S_PRE: begin
				if (tick) begin
					d.txen = 1'b1;
					d.txd = (q.cnt == edm_pkg::PRE_NIB - 8'h01) ?
						edm_pkg::SFD_NIBBLE : edm_pkg::PRE_NIBBLE;
					d.cnt = q.cnt + 8'h01;
					if (q.cnt == edm_pkg::PRE_NIB - 8'h01) begin
						d.st = S_DATA;
					end
				end
			end
			S_DATA: begin
				// One byte buffer; the next byte's fetch must finish within one nibble slot
				if (q.mreq && mem_ack_i) begin
					d.data_byte = pick_byte(mem_rdata_i, q.buf_ptr[1:0]);
					d.bvalid = 1'b1;
					d.buf_ptr = q.buf_ptr + 32'h00000001;
					d.buf_left = q.buf_left - 16'h0001;
				end else if (!q.mreq && !q.bvalid && q.buf_left != 16'h0000 &&
						q.pkt_left != 16'h0000) begin
					d.mreq = 1'b1;
					d.maddr = {q.buf_ptr[31:2], 2'h0};
				end else if (!q.mreq && q.buf_left == 16'h0000 && q.pkt_left != 16'h0000 &&
						!q.flags[edm_pkg::LAST_FRAGMENT_FLAG_BIT]) begin
					// Next fragment is read while the last byte still goes out
					d.cur = q.nxt;
					d.widx = edm_pkg::DW_NEXT;
					d.frag = 1'b1;
					d.st = S_FETCH;
				end
			end
			S_JAM: begin
				if (tick) begin
					if (q.cnt < edm_pkg::JAM_NIB) begin
						d.txen = 1'b1;
						d.txd = edm_pkg::JAM_NIBBLE;
						d.cnt = q.cnt + 8'h01;
					end else begin
						d.txen = 1'b0;
						if (!q.mreq) begin
							d.attempts = q.attempts + 5'h01;
							if (q.attempts + 5'h01 == edm_pkg::MAX_ATTEMPTS) begin
								d.abandon = 1'b1;
								d.drop = 1'b1;
								d.cur = q.pkt_head_addr;
								d.widx = edm_pkg::DW_NEXT;
								d.frag = 1'b0;
								d.st = S_FETCH;
							end else begin
								d.bo_start = 1'b1;
								d.st = S_BACKOFF;
							end
						end
					end
				end
			end
			S_BACKOFF: begin
				if (bo.done) begin
					d.cur = q.pkt_head_addr;
					d.widx = edm_pkg::DW_NEXT;
					d.frag = 1'b0;
					d.drop = 1'b0;
					d.st = S_FETCH;
				end
			end
			S_WB_LAST: begin
				// Separate write only when the last fragment is a later descriptor with a zero next pointer
				if (q.cur == q.pkt_head_addr || q.nxt != 32'h00000000) begin
					d.st = S_WB_HEAD;
				end else if (!q.mreq) begin
					d.mreq = 1'b1;
					d.mwe = 1'b1;
					d.maddr = desc_addr(q.cur, edm_pkg::DW_FLAGS);
					d.mwdata = q.flags;
					d.mwdata[edm_pkg::LIST_END_REACHED_FLAG_BIT] = 1'b1;
				end else if (mem_ack_i) begin
					d.st = S_WB_HEAD;
				end
			end
			S_WB_HEAD: begin
				if (!q.mreq) begin
					d.mreq = 1'b1;
					d.mwe = 1'b1;
					d.maddr = desc_addr(q.pkt_head_addr, edm_pkg::DW_FLAGS);
					d.mwdata = q.head_flags;
					d.mwdata[edm_pkg::MAC_HOLDS_PACKET_FLAG_BIT] = 1'b0;
					if (q.cur == q.pkt_head_addr && q.nxt == 32'h00000000) begin
						d.mwdata[edm_pkg::LIST_END_REACHED_FLAG_BIT] = 1'b1;
					end
				end else if (mem_ack_i) begin
					d.head = q.nxt;
					d.attempts = 5'h00;
					d.st = S_IDLE;
				end
			end
			default: begin
				d.st = S_IDLE;
			end
		endcase

		// Nibble output while the frame body is on the wire
		if (tick && txing) begin
			if (q.bvalid) begin
				d.txen = 1'b1;
				d.txd = q.hi ? q.data_byte[7:4] : q.data_byte[3:0];
				d.hi = !q.hi;
				if (q.hi) begin
					d.bvalid = 1'b0;
					d.pkt_left = q.pkt_left - 16'h0001;
				end
			end else begin
				d.txen = 1'b0;
				if (!done_cond || q.st != S_DATA) begin
					d.underrun = 1'b1;  // Memory too slow; frame is cut short
				end else begin
					d.frames = q.frames + 16'h0001;
				end
				if (q.st != S_DATA) begin
					d.drop = 1'b1;
				end else if (q.flags[edm_pkg::LAST_FRAGMENT_FLAG_BIT] ||
						q.nxt == 32'h00000000) begin
					d.st = S_WB_LAST;
				end else begin
					d.drop = 1'b1;
					d.cur = q.nxt;
					d.widx = edm_pkg::DW_NEXT;
					d.st = S_FETCH;
				end
			end
		end

		// Collision aborts the frame; full duplex never looks at it
		if (on_air && !q.fd && col_s) begin
			d.cnt = 8'h00;
			d.bvalid = 1'b0;
			d.st = S_JAM;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// Every output is a register field
	assign prdata_o = q.prdata;
	assign pready_o = q.pready;
	assign pslverr_o = q.pslverr;
	assign mem_req_o = q.mreq;
	assign mem_we_o = q.mwe;
	assign mem_addr_o = q.maddr;
	assign mem_wdata_o = q.mwdata;
	assign mii_txd_o = q.txd;
	assign mii_tx_en_o = q.txen;

	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!rst_n_i);

	a_fd_no_contend: assert property (q.fd |-> !(q.st inside {S_DEFER, S_IFG, S_JAM}))
		else $error("full duplex entered deferral or jam");
	a_idle_go_now: assert property ((q.st == S_SENSE && !crs_s) |=> q.st == S_PRE)
		else $error("idle medium did not start the preamble");
	a_busy_defers: assert property ((q.st inside {S_SENSE, S_IFG}) && crs_s |=> q.st == S_DEFER)
		else $error("carrier did not force deferral");
	a_col_to_jam: assert property ((on_air && !q.fd && col_s) |=> q.st == S_JAM)
		else $error("collision did not start the jam");
	a_jam_length: assert property ($fell(q.st == S_JAM) |-> $past(q.cnt) == edm_pkg::JAM_NIB)
		else $error("jam ended at the wrong nibble count");
	a_jam_backoff: assert property ($fell(q.st == S_JAM) && q.attempts < edm_pkg::MAX_ATTEMPTS
		|-> q.st == S_BACKOFF && q.bo_start)
		else $error("jam not followed by backoff");
	a_retry_cap: assert property ($fell(q.st == S_JAM) && q.attempts == edm_pkg::MAX_ATTEMPTS
		|-> q.drop && q.abandon && q.st == S_FETCH)
		else $error("sixteenth failure did not abandon the packet");
	a_desc_next: assert property ((q.st == S_FETCH && q.widx == edm_pkg::DW_NEXT && q.mreq
		&& mem_ack_i) |=> q.nxt == $past(mem_rdata_i))
		else $error("next pointer not taken from word 0");
	a_mac_holds_packet_flag_clear: assert property ((q.st == S_WB_HEAD && q.mreq && q.mwe)
		|-> !q.mwdata[edm_pkg::MAC_HOLDS_PACKET_FLAG_BIT])
		else $error("ownership flag written back set");
	a_head_advance: assert property ((q.st == S_WB_HEAD && q.mreq && mem_ack_i)
		|=> q.st == S_IDLE && q.head == $past(q.nxt) && q.attempts == 5'h00)
		else $error("list head not advanced after the packet");
endmodule

// ==== src/edm_pkg.sv ====
package edm_pkg;

	// Register byte offsets on the APB port
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_STAT   = 8'h04;
	localparam logic [7:0] REG_HEAD   = 8'h08;
	localparam logic [7:0] REG_FRAMES = 8'h0C;

	// Control and status bit positions
	localparam int CTRL_EN_BIT      = 0;
	localparam int CTRL_FD_BIT      = 1;
	localparam int STAT_BUSY_BIT    = 0;
	localparam int STAT_UNDER_BIT   = 1;
	localparam int STAT_ABANDON_BIT = 2;
	localparam int STAT_FORMAT_BIT  = 3;
	localparam int STAT_TRY_LSB     = 8;

	// Descriptor word indices and field layout
	localparam logic [1:0] DW_NEXT   = 2'h0;
	localparam logic [1:0] DW_BUF    = 2'h1;
	localparam logic [1:0] DW_OFFLEN = 2'h2;
	localparam logic [1:0] DW_FLAGS  = 2'h3;
	localparam int OFFSET_LSB                = 16;
	localparam int LEN_W                     = 16;
	localparam int FIRST_FRAGMENT_FLAG_BIT   = 31;
	localparam int LAST_FRAGMENT_FLAG_BIT    = 30;
	localparam int MAC_HOLDS_PACKET_FLAG_BIT = 29;
	localparam int LIST_END_REACHED_FLAG_BIT = 28;

	// Link timing in bit times, counted in nibbles of the media interface
	localparam int NIB_BITS  = 4;
	localparam int JAM_BITS  = 48;
	localparam int SLOT_BITS = 512;
	localparam int IPG_BITS  = 96;
	localparam int PRE_BITS  = 64;
	localparam logic [7:0] JAM_NIB  = 8'(JAM_BITS / NIB_BITS);
	localparam logic [7:0] SLOT_NIB = 8'(SLOT_BITS / NIB_BITS);
	localparam logic [7:0] IPG_NIB  = 8'(IPG_BITS / NIB_BITS);
	localparam logic [7:0] PRE_NIB  = 8'(PRE_BITS / NIB_BITS);

	// Line patterns
	localparam logic [3:0] PRE_NIBBLE = 4'h5;
	localparam logic [3:0] SFD_NIBBLE = 4'hD;
	localparam logic [3:0] JAM_NIBBLE = 4'h5;

	// Retry policy
	localparam logic [4:0]  MAX_ATTEMPTS = 5'h10;
	localparam logic [4:0]  BO_LIMIT     = 5'h0A;
	localparam logic [15:0] LFSR_SEED    = 16'hACE1;

endpackage

// ==== src/edm_bo_if.sv ====
`timescale 1ns/10ps
// Request to the backoff unit and its completion pulse
interface edm_bo_if;
	logic       start;
	logic       tick;
	logic [4:0] attempt;
	logic       done;
	modport mac  (output start, output tick, output attempt, input done);
	modport unit (input start, input tick, input attempt, output done);
endinterface

// ==== src/edm_sync.sv ====
`timescale 1ns/10ps
// Two-flop synchroniser for pins from outside the core clock domain
module edm_sync #(
	parameter int W = 3
) (
	input  wire logic         core_clk_i,
	input  wire logic         rst_n_i,
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] sync_o
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} edm_sync_regs_t;

	edm_sync_regs_t q, d;

	if (W < 1) begin : g_bad_width
		$error("edm_sync needs at least one bit");
	end

	// First stage feeds only the second stage
	always_comb begin
		d = q;
		d.s1 = async_i;
		d.s2 = q.s1;
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign sync_o = q.s2;
endmodule

// ==== src/edm_backoff.sv ====
`timescale 1ns/10ps
// Truncated binary exponential backoff timer, counted in slot times
module edm_backoff (
	input  wire logic core_clk_i,
	input  wire logic rst_n_i,
	edm_bo_if.unit    bo
);
	typedef struct packed {
		logic        busy;
		logic [9:0]  slots;
		logic [7:0]  nib;
		logic [15:0] lfsr;
		logic        done;
	} edm_bo_regs_t;

	edm_bo_regs_t q, d;
	logic [3:0]   k;
	logic [9:0]   mask;

	// Range doubles per collision and stops growing after ten
	always_comb begin
		d = q;
		d.done = 1'b0;
		d.lfsr = {q.lfsr[14:0], q.lfsr[15] ^ q.lfsr[13] ^ q.lfsr[12] ^ q.lfsr[10]};
		k = (bo.attempt > edm_pkg::BO_LIMIT) ? edm_pkg::BO_LIMIT[3:0] : bo.attempt[3:0];
		mask = 10'((11'h001 << k) - 11'h001);
		if (bo.start) begin
			d.slots = q.lfsr[9:0] & mask;
			d.nib = 8'h00;
			d.busy = (d.slots != 10'h000);
			d.done = (d.slots == 10'h000);  // Zero slots retries at once
		end else if (q.busy && bo.tick) begin
			if (q.nib == edm_pkg::SLOT_NIB - 8'h01) begin
				d.nib = 8'h00;
				d.slots = q.slots - 10'h001;
				if (q.slots == 10'h001) begin
					d.busy = 1'b0;
					d.done = 1'b1;
				end
			end else begin
				d.nib = q.nib + 8'h01;
			end
		end
	end

	// Seed must be nonzero or the generator locks up
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			q <= '0;
			q.lfsr <= edm_pkg::LFSR_SEED;
		end else begin
			q <= d;
		end
	end

	assign bo.done = q.done;
endmodule

// ==== verif/edm_phy_model.sv ====
`timescale 1ns/10ps
// Media side stand-in: free transmit clock, carrier and collision on command
module edm_phy_model (
	input  wire logic       busy_i,
	input  wire logic [7:0] col_at_i,
	input  wire logic [3:0] mii_txd_i,
	input  wire logic       mii_tx_en_i,
	output logic            mii_tx_clk_o,
	output logic            mii_crs_o,
	output logic            mii_col_o
);
	logic [3:0] nib [$];
	int         bursts = 0;
	int         gap = 0;
	int         start_gap = 0;
	logic       was_en = 1'b0;
	logic       col_q = 1'b0;
	logic       hit = 1'b0;

	// Clock runs free, since the MAC times gaps and slots on it
	initial begin
		mii_tx_clk_o = 1'b0;
		#137;
		forever #200 mii_tx_clk_o = ~mii_tx_clk_o;
	end

	// Carrier comes only from far stations; own sending is not echoed
	assign mii_crs_o = busy_i | col_q;
	assign mii_col_o = col_q;

	// Capture each burst, time the quiet gap, collide once per command
	always @(posedge mii_tx_clk_o) begin
		gap <= busy_i ? 0 : gap + 1;
		was_en <= mii_tx_en_i;
		if (col_at_i == 8'h00) hit <= 1'b0;
		if (!mii_tx_en_i) col_q <= 1'b0;
		if (mii_tx_en_i && !was_en) begin
			nib.delete();
			bursts <= bursts + 1;
			start_gap <= gap;
		end
		if (mii_tx_en_i) nib.push_back(mii_txd_i);
		if (mii_tx_en_i && !hit && col_at_i != 8'h00 && nib.size() == int'(col_at_i)) begin
			col_q <= 1'b1;
			hit <= 1'b1;
		end
	end
endmodule

// ==== verif/ethernet_desc_csma_mac_bench.sv ====
`timescale 1ns/10ps
// Drives the MAC over APB, serves its memory port, checks frames and write-back
module ethernet_desc_csma_mac_bench;
	typedef struct packed {
		logic        wr;
		logic [7:0]  addr;
		logic [31:0] wd;
		logic [31:0] rd;
		logic        err;
	} edm_row_t;
	logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, busy, err;
	logic        mem_req, mem_we, mem_ack, tx_clk, crs, col, tx_en;
	logic [7:0]  paddr, col_at;
	logic [31:0] pwdata, prdata, mem_addr, mem_wdata, mem_rdata, rd;
	logic [3:0]  txd;
	logic [31:0] mem [0:255];
	edm_row_t    rows [10];
	int          errors = 0;
	int          checked = 0;

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	edm_mac u_dut (.core_clk_i(clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .mem_req_o(mem_req), .mem_we_o(mem_we),
		.mem_addr_o(mem_addr), .mem_wdata_o(mem_wdata), .mem_rdata_i(mem_rdata),
		.mem_ack_i(mem_ack), .mii_tx_clk_i(tx_clk), .mii_crs_i(crs), .mii_col_i(col),
		.mii_txd_o(txd), .mii_tx_en_o(tx_en));

	edm_phy_model u_phy (.busy_i(busy), .col_at_i(col_at), .mii_txd_i(txd),
		.mii_tx_en_i(tx_en), .mii_tx_clk_o(tx_clk), .mii_crs_o(crs), .mii_col_o(col));

	// One-cycle memory; idle read data is scrambled so stale values never match
	always @(posedge clk) begin
		mem_ack <= mem_req && !mem_ack;
		mem_rdata <= mem_req ? mem[mem_addr[9:2]] : ~mem_rdata;
		if (mem_req && !mem_ack && mem_we) mem[mem_addr[9:2]] <= mem_wdata;
	end

	task automatic stop_test();
		$display("checks %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("FAIL %s expected %h seen %h", name, exp, got);
		end
	endtask

	// Request held until pready is seen at an edge, then released
	task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		chk("pready", 32'h1, 32'(pready));
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wait_burst(int n);
		int k;
		k = 0;
		while ((u_phy.bursts < n || tx_en !== 1'b0) && k < 20000) begin
			@(posedge clk);
			k++;
		end
		chk("burst count", 32'(n), 32'(u_phy.bursts));
	endtask

	task automatic wait_idle();
		int k;
		k = 0;
		do begin
			apb(1'b0, edm_pkg::REG_STAT, 32'h0);
			k++;
		end while (rd[edm_pkg::STAT_BUSY_BIT] !== 1'b0 && k < 100);
		chk("busy", 32'h0, 32'(rd[edm_pkg::STAT_BUSY_BIT]));
	endtask

	// Preamble, delimiter, then each byte low nibble first
	task automatic chk_frame(logic [7:0] b[$]);
		logic [3:0] e [$];
		for (int i = 0; i < 15; i++) e.push_back(edm_pkg::PRE_NIBBLE);
		e.push_back(edm_pkg::SFD_NIBBLE);
		foreach (b[i]) begin
			e.push_back(b[i][3:0]);
			e.push_back(b[i][7:4]);
		end
		chk("frame length", 32'(e.size()), 32'(u_phy.nib.size()));
		foreach (e[i]) begin
			if (i < u_phy.nib.size()) chk("nibble", 32'(e[i]), 32'(u_phy.nib[i]));
		end
	endtask

	// Deadline well above the longest backoff of the collision case
	initial begin
		#3000000;
		errors++;
		stop_test();
	end

	initial begin
		rst_n = 1'b0;
		{psel, penable, pwrite, mem_ack, busy} = '0;
		{paddr, col_at, pwdata, mem_rdata} = '0;
		foreach (mem[i]) mem[i] = 32'h0;
		mem[8'h41] = 32'h200;
		mem[8'h42] = 32'h0001_0004;
		mem[8'h43] = 32'hE000_0003;
		mem[8'h50] = 32'h160;
		mem[8'h51] = 32'h200;
		mem[8'h52] = 32'h0000_0002;
		mem[8'h53] = 32'hA000_0004;
		mem[8'h59] = 32'h204;
		mem[8'h5A] = 32'h0000_0002;
		mem[8'h5B] = 32'h4000_0000;
		mem[8'h80] = 32'hC4B3A291;
		mem[8'h81] = 32'h87654321;
		rows = '{'{0, edm_pkg::REG_CTRL, 0, 0, 0}, '{0, edm_pkg::REG_STAT, 0, 0, 0},
			'{0, edm_pkg::REG_HEAD, 0, 0, 0}, '{0, edm_pkg::REG_FRAMES, 0, 0, 0},
			'{1, edm_pkg::REG_FRAMES, 32'hFFFF, 0, 0}, '{0, edm_pkg::REG_FRAMES, 0, 0, 0},
			'{1, edm_pkg::REG_HEAD, 32'h100, 0, 0}, '{0, edm_pkg::REG_HEAD, 0, 32'h100, 0},
			'{0, 8'h10, 0, 0, 1}, '{1, 8'h14, 32'hFFFFFFFF, 0, 1}};
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		chk("idle outputs", 32'h0, {29'h0, tx_en, mem_req, pready});
		foreach (rows[i]) begin
			apb(rows[i].wr, rows[i].addr, rows[i].wd);
			chk("pslverr", 32'(rows[i].err), 32'(err));
			if (!rows[i].wr) chk("prdata", rows[i].rd, rd);
		end
		// Full duplex ignores carrier and collision
		busy <= 1'b1;
		col_at <= 8'h12;
		apb(1'b1, edm_pkg::REG_CTRL, 32'h3);
		wait_burst(1);
		chk_frame('{8'hA2, 8'hB3, 8'hC4});
		wait_idle();
		chk("single writeback", 32'hD000_0003, mem[8'h43]);
		apb(1'b0, edm_pkg::REG_HEAD, 32'h0);
		chk("head at list end", 32'h0, rd);
		// Half duplex defers on carrier, then a gap, two fragments
		col_at <= 8'h0;
		apb(1'b1, edm_pkg::REG_CTRL, 32'h1);
		apb(1'b1, edm_pkg::REG_HEAD, 32'h140);
		repeat (300) @(posedge clk);
		chk("silent while busy", 32'h1, 32'(u_phy.bursts));
		busy <= 1'b0;
		wait_burst(2);
		chk("gap", 32'h1, 32'(u_phy.start_gap >= 24 && u_phy.start_gap <= 28));
		chk_frame('{8'h91, 8'hA2, 8'h21, 8'h43});
		wait_idle();
		chk("last writeback", 32'h5000_0000, mem[8'h5B]);
		chk("first writeback", 32'h8000_0004, mem[8'h53]);
		// Collision in data: jam, back off, clean retry
		mem[8'h43] = 32'hE000_0003;
		col_at <= 8'h12;
		apb(1'b1, edm_pkg::REG_HEAD, 32'h100);
		wait_burst(3);
		chk("aborted", 32'h1, 32'(u_phy.nib.size() <= 32));
		for (int i = 1; i <= 12; i++) begin
			chk("jam", 32'h5, 32'(u_phy.nib[u_phy.nib.size() - i]));
		end
		col_at <= 8'h0;
		wait_burst(4);
		chk_frame('{8'hA2, 8'hB3, 8'hC4});
		wait_idle();
		apb(1'b0, edm_pkg::REG_FRAMES, 32'h0);
		chk("clean frames", 32'h3, rd);
		// Owned but not first: format error, MAC disables itself, head is kept
		mem[8'h43] = 32'h6000_0003;
		apb(1'b1, edm_pkg::REG_HEAD, 32'h100);
		wait_idle();
		apb(1'b0, edm_pkg::REG_STAT, 32'h0);
		chk("format error", 32'h8, rd);
		apb(1'b0, edm_pkg::REG_CTRL, 32'h0);
		chk("disabled", 32'h0, rd);
		apb(1'b0, edm_pkg::REG_HEAD, 32'h0);
		chk("head kept", 32'h100, rd);
		chk("no frame sent", 32'h4, 32'(u_phy.bursts));
		// Sticky flag clears by writing one
		apb(1'b1, edm_pkg::REG_STAT, 32'h8);
		apb(1'b0, edm_pkg::REG_STAT, 32'h0);
		chk("flag cleared", 32'h0, rd);
		stop_test();
	end
endmodule
